//--- verilog/uhpsf_defs.svh
`ifndef UHPSF_DEFS_SVH
`define UHPSF_DEFS_SVH

// Register word offsets, one 32-bit word per pipe
`define UHPSF_STATUS_OFS      12'h530
`define UHPSF_STATUS_CLR_OFS  12'h560
`define UHPSF_STATUS_SET_OFS  12'h590
`define UHPSF_CTRL_OFS        12'h5c0
`define UHPSF_CTRL_SET_OFS    12'h5f0
`define UHPSF_CTRL_CLR_OFS    12'h620
`define UHPSF_PIPE_STRIDE     12'h004

// Flag bit positions, shared by status, clear, set and enable words
`define UHPSF_IN_RCVD_BIT     0
`define UHPSF_OUT_SENT_BIT    1
`define UHPSF_SETUP_UNDER_BIT 2
`define UHPSF_FAULT_BIT       3
`define UHPSF_NAK_BIT         4
`define UHPSF_OVERRUN_BIT     5
`define UHPSF_STALL_CRC_BIT   6
`define UHPSF_SHORT_BIT       7

// Status word fields
`define UHPSF_TOGGLE_LSB      8
`define UHPSF_COUNT_LSB       12
`define UHPSF_RW_OK_BIT       16

// Control word fields
`define UHPSF_BUSY_EN_BIT     12
`define UHPSF_HOLD_BIT        17

// Pipe type codes
`define UHPSF_TYPE_CONTROL    2'h0
`define UHPSF_TYPE_ISO        2'h1
`define UHPSF_TYPE_BULK       2'h2
`define UHPSF_TYPE_INTR       2'h3

// Reset values
`define UHPSF_FLAGS_RST       8'h00
`define UHPSF_CTRL_RST        32'h0000_0000

`endif

//--- verilog/uhpsf_pkg.sv
package uhpsf_pkg;

    // One-cycle event pulses from the transfer engine for one pipe
    typedef struct packed {
        logic short_pkt;
        logic stall;
        logic crc_err;
        logic overrun;
        logic nak;
        logic fault;
        logic setup_free;
        logic underrun;
        logic out_free;
        logic in_rcvd;
    } uhpsf_event_type;

    // Levels describing the pipe as configured and as the engine sees it
    typedef struct packed {
        logic [1:0] pipe_type;
        logic       dir_in;
        logic [1:0] bank_total;
        logic [1:0] busy_count;
        logic       toggle;
        logic       rw_ok;
        logic       fault_source;
    } uhpsf_pipe_state_type;

    // Actions the engine must take for one pipe
    typedef struct packed {
        logic send_zlp;
        logic drop_pkt;
        logic ack_dropped;
    } uhpsf_action_type;

endpackage

//--- verilog/uhpsf_flag_cell.sv
`timescale 1ns/100ps
`include "uhpsf_defs.svh"

module uhpsf_flag_cell
(
    // Clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          resetn_i,
    // Engine side
    input  wire uhpsf_pkg::uhpsf_event_type    ev_i,
    input  wire uhpsf_pkg::uhpsf_pipe_state_type st_i,
    // Software writes, already decoded for this pipe
    input  wire logic [7:0]                    clr_mask_i,
    input  wire logic [7:0]                    set_mask_i,
    input  wire logic                          busy_force_i,
    // Flags
    output logic      [7:0]                    flags_o,
    output logic      [1:0]                    busy_count_o
);

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] hw_set;
    logic [7:0] clr_eff;
    logic       force_reg;
    logic [1:0] count_seen_reg;
    logic       is_iso;
    logic       is_per;

    assign is_iso = (st_i.pipe_type == `UHPSF_TYPE_ISO);
    assign is_per = is_iso || (st_i.pipe_type == `UHPSF_TYPE_INTR);

    always_comb
    begin
        hw_set = 8'h00;
        hw_set[`UHPSF_IN_RCVD_BIT]     = ev_i.in_rcvd;
        hw_set[`UHPSF_OUT_SENT_BIT]    = ev_i.out_free;
        hw_set[`UHPSF_SETUP_UNDER_BIT] = (st_i.pipe_type == `UHPSF_TYPE_CONTROL) ? ev_i.setup_free
                                       : (is_per && ev_i.underrun);
        hw_set[`UHPSF_FAULT_BIT]       = ev_i.fault;
        hw_set[`UHPSF_NAK_BIT]         = ev_i.nak;
        hw_set[`UHPSF_OVERRUN_BIT]     = ev_i.overrun;
        hw_set[`UHPSF_STALL_CRC_BIT]   = is_iso ? ev_i.crc_err : ev_i.stall;
        hw_set[`UHPSF_SHORT_BIT]       = ev_i.short_pkt;
    end

    // Fault has no clear bit; it follows its source going away
    always_comb
    begin
        clr_eff = clr_mask_i;
        clr_eff[`UHPSF_FAULT_BIT] = !st_i.fault_source;
    end

    // Set wins over clear so an event in the clearing cycle survives
    assign flags_next = (flags_reg & ~clr_eff) | hw_set | set_mask_i;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            flags_reg <= `UHPSF_FLAGS_RST;
        else
            flags_reg <= flags_next;
    end

    // Forced count bit holds until the engine's count next moves
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            force_reg      <= 1'b0;
            count_seen_reg <= 2'h0;
        end
        else
        begin
            count_seen_reg <= st_i.busy_count;
            if (busy_force_i)
                force_reg <= 1'b1;
            else if (count_seen_reg != st_i.busy_count)
                force_reg <= 1'b0;
        end
    end

    assign flags_o      = flags_reg;
    assign busy_count_o = st_i.busy_count | {1'b0, force_reg};

endmodule // uhpsf_flag_cell

//--- verilog/uhpsf_top.sv
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "uhpsf_defs.svh"


module uhpsf_top
#(
    parameter int NPIPE = 8
)
(
    // Clock and reset
    input  wire logic                                      mclk_i,
    input  wire logic                                      resetn_i,
    // Register port
    input  wire logic [11:0]                               addr_i,
    input  wire logic [31:0]                               wdata_i,
    input  wire logic                                      wr_i,
    input  wire logic                                      rd_i,
    output logic      [31:0]                               rdata_o,
    // Transfer engine, per pipe
    input  wire uhpsf_pkg::uhpsf_event_type    [NPIPE-1:0] ev_i,
    input  wire uhpsf_pkg::uhpsf_pipe_state_type [NPIPE-1:0] st_i,
    output uhpsf_pkg::uhpsf_action_type        [NPIPE-1:0] action_o,
    output logic      [NPIPE-1:0]                          pipe_hold_o,
    output logic      [NPIPE-1:0]                          fifo_access_ok_o,
    // Interrupt lines towards the controller's own interrupt merge
    output logic      [NPIPE-1:0]                          pipe_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    logic [11:0] stat_rel;
    logic [11:0] sclr_rel;
    logic [11:0] sset_rel;
    logic [11:0] ctrl_rel;
    logic [11:0] cset_rel;
    logic [11:0] cclr_rel;
    logic        aligned;

    assign aligned  = (addr_i[1:0] == 2'h0);
    assign stat_rel = addr_i - `UHPSF_STATUS_OFS;
    assign sclr_rel = addr_i - `UHPSF_STATUS_CLR_OFS;
    assign sset_rel = addr_i - `UHPSF_STATUS_SET_OFS;
    assign ctrl_rel = addr_i - `UHPSF_CTRL_OFS;
    assign cset_rel = addr_i - `UHPSF_CTRL_SET_OFS;
    assign cclr_rel = addr_i - `UHPSF_CTRL_CLR_OFS;

    function automatic logic hit(input logic [11:0] rel);
        hit = (rel[11:2] < 10'(NPIPE));
    endfunction

    logic [9:0] pipe_idx;
    logic       hit_stat;
    logic       hit_sclr;
    logic       hit_sset;
    logic       hit_ctrl;
    logic       hit_cset;
    logic       hit_cclr;

    always_comb
    begin
        hit_stat = aligned && hit(stat_rel);
        hit_sclr = aligned && hit(sclr_rel);
        hit_sset = aligned && hit(sset_rel);
        hit_ctrl = aligned && hit(ctrl_rel);
        hit_cset = aligned && hit(cset_rel);
        hit_cclr = aligned && hit(cclr_rel);
        pipe_idx = 10'h000;
        // Windows never overlap, so the priority only picks the one live index
        if (hit_stat)
        begin
            pipe_idx = stat_rel[11:2];
        end
        else if (hit_sclr)
        begin
            pipe_idx = sclr_rel[11:2];
        end
        else if (hit_sset)
        begin
            pipe_idx = sset_rel[11:2];
        end
        else if (hit_ctrl)
        begin
            pipe_idx = ctrl_rel[11:2];
        end
        else if (hit_cset)
        begin
            pipe_idx = cset_rel[11:2];
        end
        else if (hit_cclr)
        begin
            pipe_idx = cclr_rel[11:2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-pipe logic

    logic [NPIPE-1:0][7:0]  flags;
    logic [NPIPE-1:0][1:0]  count;
    logic [NPIPE-1:0][31:0] status_word;
    logic [NPIPE-1:0][31:0] ctrl_word;

    genvar gp;
    generate
        for (gp = 0; gp < NPIPE; gp++)
        begin : g_pipe
            logic        sel;
            logic [7:0]  clr_mask;
            logic [7:0]  set_mask;
            logic        busy_force;
            logic [7:0]  en_reg;
            logic        busy_en_reg;
            logic        hold_reg;
            logic        bank_irq;
            logic        flag_irq;
            logic        stall_now;
            logic        fault_now;
            logic        non_iso;
            logic        is_per;
            logic        cset_wr;
            logic        cclr_wr;
            logic        irq_next;

            assign sel        = (pipe_idx == 10'(gp));
            assign non_iso    = (st_i[gp].pipe_type != `UHPSF_TYPE_ISO);
            assign is_per     = !non_iso || (st_i[gp].pipe_type == `UHPSF_TYPE_INTR);
            // Status clear and set: write-one, fault bit has no clear
            always_comb
            begin
                clr_mask   = 8'h00;
                set_mask   = 8'h00;
                busy_force = 1'b0;
                if (wr_i && sel && hit_sclr)
                begin
                    clr_mask = wdata_i[7:0];
                end
                if (wr_i && sel && hit_sset)
                begin
                    set_mask   = wdata_i[7:0];
                    busy_force = wdata_i[`UHPSF_COUNT_LSB];
                end
            end

            assign cset_wr = wr_i && sel && hit_cset;
            assign cclr_wr = wr_i && sel && hit_cclr;

            uhpsf_flag_cell u_cell
            (
                .mclk_i       (mclk_i),
                .resetn_i     (resetn_i),
                .ev_i         (ev_i[gp]),
                .st_i         (st_i[gp]),
                .clr_mask_i   (clr_mask),
                .set_mask_i   (set_mask),
                .busy_force_i (busy_force),
                .flags_o      (flags[gp]),
                .busy_count_o (count[gp])
            );

            // Enables: set and clear words only; set wins if both in one write stream
            always_ff @(posedge mclk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    en_reg      <= `UHPSF_FLAGS_RST;
                    busy_en_reg <= 1'b0;
                end
                else if (cset_wr)
                begin
                    en_reg      <= en_reg | wdata_i[7:0];
                    busy_en_reg <= busy_en_reg | wdata_i[`UHPSF_BUSY_EN_BIT];
                end
                else if (cclr_wr)
                begin
                    en_reg      <= en_reg & ~wdata_i[7:0];
                    busy_en_reg <= busy_en_reg & ~wdata_i[`UHPSF_BUSY_EN_BIT];
                end
            end

            // Stall on non-isochronous and any fault freeze the pipe; hardware set wins
            assign stall_now = ev_i[gp].stall && non_iso;
            assign fault_now = ev_i[gp].fault;

            always_ff @(posedge mclk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    hold_reg <= 1'b0;
                end
                else if (stall_now || fault_now)
                begin
                    hold_reg <= 1'b1;
                end
                else if (cset_wr && wdata_i[`UHPSF_HOLD_BIT])
                begin
                    hold_reg <= 1'b1;
                end
                else if (cclr_wr && wdata_i[`UHPSF_HOLD_BIT])
                begin
                    hold_reg <= 1'b0;
                end
            end

            // OUT: all banks busy; IN: all banks free
            always_comb
            begin
                if (st_i[gp].dir_in)
                begin
                    bank_irq = (count[gp] == 2'h0);
                end
                else
                begin
                    bank_irq = (count[gp] == st_i[gp].bank_total);
                end
            end

            assign flag_irq = |(flags[gp] & en_reg);

            // Flag sources and the bank-count source merge into one line per pipe
            always_comb
            begin
                irq_next = flag_irq;
                if (busy_en_reg && bank_irq)
                begin
                    irq_next = 1'b1;
                end
            end

            always_ff @(posedge mclk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    pipe_irq_o[gp] <= 1'b0;
                end
                else
                begin
                    pipe_irq_o[gp] <= irq_next;
                end
            end

            // Underflow reactions go back to the engine as one-cycle pulses
            always_ff @(posedge mclk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    action_o[gp] <= '0;
                end
                else
                begin
                    action_o[gp].send_zlp    <= ev_i[gp].underrun && is_per
                                                && !st_i[gp].dir_in;
                    action_o[gp].drop_pkt    <= ev_i[gp].underrun && is_per
                                                && st_i[gp].dir_in;
                    action_o[gp].ack_dropped <= ev_i[gp].underrun && st_i[gp].dir_in
                                                && (st_i[gp].pipe_type == `UHPSF_TYPE_INTR);
                end
            end

            // Access permission is masked while stalled or faulted
            always_comb
            begin
                fifo_access_ok_o[gp] = st_i[gp].rw_ok
                    && !(non_iso && flags[gp][`UHPSF_STALL_CRC_BIT])
                    && !flags[gp][`UHPSF_FAULT_BIT];
            end

            always_comb
            begin
                status_word[gp] = 32'h0000_0000;
                status_word[gp][7:0] = flags[gp];
                // Toggle: next sent on OUT, received on IN; upper bit always zero
                status_word[gp][`UHPSF_TOGGLE_LSB +: 2]  = {1'b0, st_i[gp].toggle};
                status_word[gp][`UHPSF_COUNT_LSB +: 2]   = count[gp];
                status_word[gp][`UHPSF_RW_OK_BIT]        = fifo_access_ok_o[gp];
            end

            always_comb
            begin
                ctrl_word[gp] = `UHPSF_CTRL_RST;
                ctrl_word[gp][7:0]                = en_reg;
                ctrl_word[gp][`UHPSF_BUSY_EN_BIT] = busy_en_reg;
                ctrl_word[gp][`UHPSF_HOLD_BIT]    = hold_reg;
            end

            assign pipe_hold_o[gp] = hold_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero for write-only and unmapped

    logic [31:0] rdata_next;
    logic [2:0]  rd_pipe;

    assign rd_pipe = pipe_idx[2:0];

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (hit_stat)
        begin
            rdata_next = status_word[rd_pipe];
        end
        else if (hit_ctrl)
        begin
            rdata_next = ctrl_word[rd_pipe];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= 32'h0000_0000;
        end
        else if (rd_i)
        begin
            rdata_o <= rdata_next;
        end
        else
        begin
            // Zero outside the answer slot keeps a stale word off the bus
            rdata_o <= 32'h0000_0000;
        end
    end

endmodule // uhpsf_top

//--- verification/uhpsf_periph_model.sv
`timescale 1ns/100ps

// Far-side stand-in: turns one bench request into a one-cycle event on one pipe,
// either at once or after a few idle cycles, as a slow peripheral would answer
module uhpsf_periph_model
(
    // Clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        resetn_i,
    // Bench request
    input  wire logic                        go_i,
    input  wire logic [2:0]                  pipe_i,
    input  wire logic [9:0]                  kind_i,
    input  wire logic [1:0]                  delay_i,
    // Handshake and packet results, per pipe
    output uhpsf_pkg::uhpsf_event_type [7:0] ev_o
);
    logic       arm_reg;
    logic [1:0] wait_reg;
    logic [2:0] pipe_reg;
    logic [9:0] kind_reg;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            arm_reg <= 1'b0;
            wait_reg <= 2'h0;
            pipe_reg <= 3'h0;
            kind_reg <= 10'h000;
            ev_o <= '0;
        end
        else
        begin
            ev_o <= '0;
            if (go_i)
            begin
                arm_reg <= 1'b1;
                wait_reg <= delay_i;
                pipe_reg <= pipe_i;
                kind_reg <= kind_i;
            end
            else if (arm_reg && wait_reg == 2'h0)
            begin
                ev_o[pipe_reg] <= kind_reg;
                arm_reg <= 1'b0;
            end
            else if (arm_reg)
                wait_reg <= wait_reg - 2'h1;
        end
    end
endmodule // uhpsf_periph_model

//--- verification/uhpsf_top_asserts.sv
`timescale 1ns/100ps
`include "uhpsf_defs.svh"

module uhpsf_top_asserts
#(
    parameter int NPIPE = 8
)
(
    // Clock and reset
    input wire logic                                        mclk_i,
    input wire logic                                        resetn_i,
    // Register port
    input wire logic [11:0]                                 addr_i,
    input wire logic [31:0]                                 wdata_i,
    input wire logic                                        wr_i,
    input wire logic                                        rd_i,
    input wire logic [31:0]                                 rdata_o,
    // Engine side
    input wire uhpsf_pkg::uhpsf_event_type [NPIPE-1:0]      ev_i,
    input wire uhpsf_pkg::uhpsf_pipe_state_type [NPIPE-1:0] st_i,
    input wire uhpsf_pkg::uhpsf_action_type [NPIPE-1:0]     action_o,
    input wire logic [NPIPE-1:0]                            pipe_hold_o,
    input wire logic [NPIPE-1:0]                            fifo_access_ok_o,
    input wire logic [NPIPE-1:0]                            pipe_irq_o
);
    // Pipes are identical copies, so watching pipe 0 keeps the checker small
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // Type codes 1 and 3 (isochronous, interrupt) share a set low bit
    sequence s_under_out;
        ev_i[0].underrun && !st_i[0].dir_in && st_i[0].pipe_type[0];
    endsequence
    sequence s_under_in;
        ev_i[0].underrun && st_i[0].dir_in && st_i[0].pipe_type[0];
    endsequence
    sequence s_fault_kept;
        ev_i[0].fault ##1 st_i[0].fault_source;
    endsequence

    a_zlp_on_under: assert property (s_under_out |=> action_o[0].send_zlp)
        else $error("no zero-length packet after underflow");
    a_zlp_has_cause: assert property (action_o[0].send_zlp |-> $past(ev_i[0].underrun))
        else $error("zero-length packet without underflow");
    a_drop_on_under: assert property (s_under_in |=> action_o[0].drop_pkt
        && action_o[0].ack_dropped == ($past(st_i[0].pipe_type) == `UHPSF_TYPE_INTR))
        else $error("dropped packet handling wrong");
    a_stall_freezes: assert property (ev_i[0].stall && st_i[0].pipe_type != `UHPSF_TYPE_ISO
        |=> pipe_hold_o[0])
        else $error("stall did not freeze pipe");
    a_fault_freezes: assert property (ev_i[0].fault |=> pipe_hold_o[0])
        else $error("fault did not freeze pipe");
    a_hold_persists: assert property (pipe_hold_o[0] && !(wr_i && addr_i == 12'h620
        && wdata_i[17]) |=> pipe_hold_o[0])
        else $error("freeze dropped without clear write");
    a_fault_blocks: assert property (s_fault_kept |-> !fifo_access_ok_o[0])
        else $error("access allowed while fault flag set");
    a_wo_reads_zero: assert property (rd_i && addr_i >= 12'h560 && addr_i < 12'h5c0
        |=> rdata_o == 32'h0)
        else $error("write-only word read nonzero");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read slot");
    a_reset_clean: assert property ($rose(resetn_i) |-> pipe_irq_o == '0 && pipe_hold_o == '0)
        else $error("outputs not clear after reset");
endmodule // uhpsf_top_asserts

bind uhpsf_top uhpsf_top_asserts #(.NPIPE(NPIPE)) i_chk
(
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .ev_i(ev_i),
    .st_i(st_i),
    .action_o(action_o),
    .pipe_hold_o(pipe_hold_o),
    .fifo_access_ok_o(fifo_access_ok_o),
    .pipe_irq_o(pipe_irq_o)
);

//--- verification/uhpsf_top_tb.sv
`timescale 1ns/100ps

module uhpsf_top_tb;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic        go = 1'b0;
    logic        pend = 1'b0;
    logic [2:0]  pipe = 3'h0;
    logic [9:0]  kind = 10'h000;
    logic [1:0]  dly = 2'h0;
    logic [7:0]  hold, acc, irq;
    logic [31:0] exp_q[$];
    int          bad_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          seed = 17279;
    uhpsf_pkg::uhpsf_event_type [7:0]      ev;
    uhpsf_pkg::uhpsf_pipe_state_type [7:0] st = '0;
    uhpsf_pkg::uhpsf_action_type [7:0]     act;

    always #20 mclk_i = ~mclk_i;

    uhpsf_top #(.NPIPE(8)) i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ev_i(ev), .st_i(st),
        .action_o(act), .pipe_hold_o(hold), .fifo_access_ok_o(acc), .pipe_irq_o(irq));
    uhpsf_periph_model i_peer (.mclk_i(mclk_i), .resetn_i(resetn_i), .go_i(go), .pipe_i(pipe),
        .kind_i(kind), .delay_i(dly), .ev_o(ev));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A read notes its expected word; the gap cycle keeps strobes one pulse each
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        if (!w)
            exp_q.push_back(d);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= w ? d : 32'h0;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Waits long enough for the slowest peer answer plus flag and interrupt delay
    task automatic fire(input logic [2:0] p, input int k, input logic [1:0] d);
        pipe <= p;
        kind <= 10'h200 >> k;
        dly <= d;
        go <= 1'b1;
        @(posedge mclk_i);
        go <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask

    function automatic logic [31:0] stat(input int p, input logic [7:0] f);
        logic ok;
        ok = st[p].rw_ok & !(st[p].pipe_type != 2'h1 & f[6]) & !f[3];
        return {15'h0, ok, 2'h0, st[p].busy_count, 3'h0, st[p].toggle, f};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk_i)
    begin
        pend <= rd_i;
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            conclude();
        end
    end

    // Read data stand only in the cycle after the strobe, so look mid-cycle
    always @(negedge mclk_i)
        if (pend)
            chk("rdata", exp_q.size() ? exp_q.pop_front() : 32'hxxxxxxxx, rdata_o);

    initial
    begin
        int          fb[10] = '{7, 6, 6, 5, 4, 3, 2, 2, 1, 0};
        logic [1:0]  pt[10] = '{2'h2, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h3, 2'h2, 2'h2};
        logic [1:0]  rt[3] = '{2'h1, 2'h2, 2'h1};
        int          rk[3] = '{1, 2, 7};
        logic [7:0]  rf[3] = '{8'h00, 8'h00, 8'h04};
        logic [11:0] base[4] = '{12'h530, 12'h5c0, 12'h560, 12'h590};
        logic [31:0] r;
        logic        hk;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        for (int i = 0; i < 32; i++)
            bus(1'b0, base[i / 8] + 12'(4 * (i % 8)), 32'h0);
        bus(1'b0, 12'h700, 32'h0);
        for (int k = 0; k < 10; k++)
        begin
            r = $random(seed);
            hk = (k == 1 || k == 5);
            st[0] <= {pt[k], 1'b1, 2'h3, 1'b0, r[1], r[2], r[3], 1'b1};
            @(posedge mclk_i);
            bus(1'b1, 12'h5f0, 32'h1 << fb[k]);
            fire(3'h0, k, r[5:4]);
            chk("irq", 32'h1, 32'(irq[0]));
            chk("hold", 32'(hk), 32'(hold[0]));
            chk("acc", stat(0, 8'h1 << fb[k]) >> 16, 32'(acc[0]));
            bus(1'b0, 12'h530, stat(0, 8'h1 << fb[k]));
            bus(1'b0, 12'h5c0, (32'h1 << fb[k]) | (hk ? 32'h20000 : 32'h0));
            if (k == 5)
                st[0].fault_source <= 1'b0;
            else
                bus(1'b1, 12'h560, 32'h1 << fb[k]);
            bus(1'b1, 12'h620, 32'h20000 | (32'h1 << fb[k]));
            repeat (2) @(posedge mclk_i);
            chk("irq", 32'h0, 32'(irq[0]));
            chk("hold", 32'h0, 32'(hold[0]));
            bus(1'b0, 12'h530, stat(0, 8'h00));
        end
        // Bit 6 and bit 2 events that the pipe type must refuse or accept
        for (int j = 0; j < 3; j++)
        begin
            st[0] <= {rt[j], j != 2, 2'h3, 2'h0, 1'b0, 1'b1, 1'b1};
            @(posedge mclk_i);
            fire(3'h0, rk[j], 2'h0);
            bus(1'b0, 12'h530, stat(0, rf[j]));
            chk("hold", 32'h0, 32'(hold[0]));
            bus(1'b1, 12'h560, 32'h4);
        end
        st[3] <= {2'h2, 1'b0, 2'h2, 2'h0, 1'b0, 1'b1, 1'b1};
        @(posedge mclk_i);
        bus(1'b1, 12'h59c, 32'h10ff);
        bus(1'b0, 12'h53c, stat(3, 8'hff) | 32'h1000);
        bus(1'b1, 12'h56c, 32'hff);
        bus(1'b0, 12'h53c, stat(3, 8'h08) | 32'h1000);
        st[3].fault_source <= 1'b0;
        bus(1'b1, 12'h5fc, 32'h1000);
        chk("irq3", 32'h0, 32'(irq[3]));
        st[3].busy_count <= 2'h2;
        repeat (3) @(posedge mclk_i);
        chk("irq3", 32'h1, 32'(irq[3]));
        bus(1'b0, 12'h53c, stat(3, 8'h00));
        st[3].dir_in <= 1'b1;
        st[3].busy_count <= 2'h1;
        repeat (3) @(posedge mclk_i);
        chk("irq3", 32'h0, 32'(irq[3]));
        st[3].busy_count <= 2'h0;
        repeat (3) @(posedge mclk_i);
        chk("irq3", 32'h1, 32'(irq[3]));
        bus(1'b1, 12'h62c, 32'h1000);
        repeat (2) @(posedge mclk_i);
        chk("irq3", 32'h0, 32'(irq[3]));
        conclude();
    end
endmodule // uhpsf_top_tb
